// [common/wtad_consts.svh]
// constants of the wake-up timer and amplitude detector
`ifndef WTAD_CONSTS_SVH
`define WTAD_CONSTS_SVH
// register indices, byte address is four times the index
`define WTAD_IDX_AUX 8'h30
`define WTAD_IDX_WAKE 8'h31
`define WTAD_IDX_AMPCFG 8'h32
`define WTAD_IDX_AMPREF 8'h33
`define WTAD_IDX_AVG 8'h34
`define WTAD_IDX_RESULT 8'h35
`define WTAD_IDX_CMD 8'h3E
`define WTAD_BYTE_RESET 8'h00
// wake-up control fields
`define WTAD_WU_RANGE 7
`define WTAD_WU_CODE_HI 6
`define WTAD_WU_CODE_LO 4
`define WTAD_WU_IRQ 3
`define WTAD_WU_AMP 2
`define WTAD_WU_PHASE 1
`define WTAD_WU_CAP 0
// amplitude configuration fields
`define WTAD_AM_THR_HI 7
`define WTAD_AM_THR_LO 4
`define WTAD_AM_INCL 3
`define WTAD_AM_WSEL_HI 2
`define WTAD_AM_WSEL_LO 1
`define WTAD_AM_SRC 0
// command register: bit that runs set-default
`define WTAD_CMD_SETDEF 0
// weight 4 is a shift of two
`define WTAD_WEIGHT_SHIFT_BASE 4'h2
// bus answers
`define WTAD_RESP_OKAY 2'b00
`define WTAD_RESP_SLVERR 2'b10
// timing
`define WTAD_CLK_PERIOD_NS 8
`define WTAD_NS_PER_MS 1000000
`define WTAD_FINE_STEP_MS 10
`define WTAD_COARSE_STEP_MS 100
`endif

// [common/wtad_pkg.sv]
// types of the wake-up timer and amplitude detector
package wtad_pkg;
	typedef logic [7:0] wtad_byte_t;
	typedef enum logic [1:0] {
		WTAD_IDLE = 2'b00,
		WTAD_MEAS = 2'b01
	} wtad_state_e;
endpackage

// [rtl/wtad_top.sv]
// wake-up timer with amplitude detection behind an axi4-lite slave
// Contract
// - range bit: clear 100 ms, set 10 ms
// - timeout is code plus one steps
// - irq-every-timeout bit raises interrupt each timeout
// - amplitude measure at timeout, interrupt beyond threshold
// - phase measure at timeout, interrupt beyond threshold
// - capacitance measure at timeout, interrupt beyond threshold
// - upper nibble sets amplitude delta threshold
// - include bit decides if triggering result averages
// - weight select: 4, 8, 16, 32
// - source bit: fixed reference or running average
// - average readable, zero after reset or default
// - last result readable, zero after reset/default
// - aux bits 7..4: channel, field, tx, crystal
// - aux bit 3 receiver enabled, 2 receiving
// - aux bit 1 peer detect, 0 collision avoid
// - control and config clear at reset/default
// - aux status zero after reset/default
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "wtad_consts.svh"
module wtad_top
	import wtad_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int CNT_W = 24,
	parameter int FINE_STEP_CYC = `WTAD_FINE_STEP_MS * `WTAD_NS_PER_MS / `WTAD_CLK_PERIOD_NS,
	parameter int COARSE_STEP_CYC = `WTAD_COARSE_STEP_MS * `WTAD_NS_PER_MS / `WTAD_CLK_PERIOD_NS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wakeup_enable,
	input wire logic amp_done,
	input wire logic [7:0] amp_result,
	input wire logic phase_done,
	input wire logic phase_exceeded,
	input wire logic cap_done,
	input wire logic cap_exceeded,
	input wire logic demod_pm_selected,
	input wire logic external_field_present,
	input wire logic transmitter_active,
	input wire logic crystal_stable,
	input wire logic receiver_enabled,
	input wire logic receiver_busy,
	input wire logic peer_detect_active,
	input wire logic collision_avoid_detect,
	output logic amp_meas_start,
	output logic phase_meas_start,
	output logic cap_meas_start,
	output logic irq_timeout,
	output logic irq_amplitude,
	output logic irq_phase,
	output logic irq_cap
);
	// all checks below run on aclk and pause during reset
	default clocking cb_chk @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// word index of a byte address, all ones when unaligned or out of range
	function automatic logic [7:0] wtad_index(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] idx;
		idx = addr >> 2;
		if (addr[1:0] != 2'b00 || idx > ADDR_W'(8'hFF)) begin
			return 8'hFF;
		end
		return idx[7:0];
	endfunction

	// absolute difference of two bytes
	function automatic wtad_byte_t wtad_absdiff(input wtad_byte_t a, input wtad_byte_t b);
		return (a > b) ? (a - b) : (b - a);
	endfunction

	// average plus difference over weight, cut to eight bits
	function automatic wtad_byte_t wtad_avg_update(input wtad_byte_t avg, input wtad_byte_t res,
		input logic [1:0] wsel);
		logic signed [9:0] diff;
		logic signed [9:0] step;
		logic [3:0] sh;
		diff = $signed({2'b00, res}) - $signed({2'b00, avg});
		sh = `WTAD_WEIGHT_SHIFT_BASE + {2'b00, wsel};
		step = diff >>> sh;
		return avg + step[7:0];
	endfunction

	wtad_byte_t aux_reg, wake_reg, ampcfg_reg, ampref_reg, avg_reg, result_reg;
	wtad_state_e state_reg;
	logic aw_have_reg, w_have_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic [CNT_W-1:0] base_cnt_reg;
	logic [2:0] step_cnt_reg;
	logic wr_fire, wr_ok, set_default, wake_write, timer_run, base_last, timer_expire;
	logic [7:0] wr_idx, rd_idx;
	logic [CNT_W-1:0] step_cyc;
	wtad_byte_t ref_sel, amp_diff;
	logic amp_take, amp_over;

	// write decode and side effects
	assign wr_fire = ce && aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_idx = wtad_index(awaddr_reg);
	assign wr_ok = wr_idx == `WTAD_IDX_WAKE || wr_idx == `WTAD_IDX_AMPCFG ||
		wr_idx == `WTAD_IDX_AMPREF || wr_idx == `WTAD_IDX_CMD;
	assign set_default = wr_fire && wstrb0_reg && wr_idx == `WTAD_IDX_CMD &&
		wdata_reg[`WTAD_CMD_SETDEF];
	assign wake_write = wr_fire && wstrb0_reg && wr_idx == `WTAD_IDX_WAKE;

	// write channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= `WTAD_BYTE_RESET;
			wstrb0_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WTAD_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
				w_have_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `WTAD_RESP_OKAY : `WTAD_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel, answer registered on the edge that takes the address
	assign rd_idx = wtad_index(s_axi_araddr);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `WTAD_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `WTAD_RESP_OKAY;
				s_axi_rdata <= '0;
				unique case (rd_idx)
					`WTAD_IDX_AUX: s_axi_rdata[7:0] <= aux_reg;
					`WTAD_IDX_WAKE: s_axi_rdata[7:0] <= wake_reg;
					`WTAD_IDX_AMPCFG: s_axi_rdata[7:0] <= ampcfg_reg;
					`WTAD_IDX_AMPREF: s_axi_rdata[7:0] <= ampref_reg;
					`WTAD_IDX_AVG: s_axi_rdata[7:0] <= avg_reg;
					`WTAD_IDX_RESULT: s_axi_rdata[7:0] <= result_reg;
					`WTAD_IDX_CMD: s_axi_rdata[7:0] <= `WTAD_BYTE_RESET;
					default: s_axi_rresp <= `WTAD_RESP_SLVERR;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// software registers, cleared by the set-default command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_reg <= `WTAD_BYTE_RESET;
			ampcfg_reg <= `WTAD_BYTE_RESET;
			ampref_reg <= `WTAD_BYTE_RESET;
		end else if (ce) begin
			if (set_default) begin
				wake_reg <= `WTAD_BYTE_RESET;
				ampcfg_reg <= `WTAD_BYTE_RESET;
				ampref_reg <= `WTAD_BYTE_RESET;
			end else if (wr_fire && wstrb0_reg) begin
				if (wr_idx == `WTAD_IDX_WAKE) begin
					wake_reg <= wdata_reg;
				end
				if (wr_idx == `WTAD_IDX_AMPCFG) begin
					ampcfg_reg <= wdata_reg;
				end
				if (wr_idx == `WTAD_IDX_AMPREF) begin
					ampref_reg <= wdata_reg;
				end
			end
		end
	end

	// auxiliary status follows the device states, zero on set-default
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_reg <= `WTAD_BYTE_RESET;
		end else if (ce) begin
			if (set_default) begin
				aux_reg <= `WTAD_BYTE_RESET;
			end else begin
				aux_reg <= {demod_pm_selected, external_field_present, transmitter_active,
					crystal_stable, receiver_enabled, receiver_busy, peer_detect_active,
					collision_avoid_detect};
			end
		end
	end

	// wake-up timer, restarted by a control write
	assign step_cyc = wake_reg[`WTAD_WU_RANGE] ? CNT_W'(FINE_STEP_CYC) :
		CNT_W'(COARSE_STEP_CYC);
	assign timer_run = wakeup_enable && !wake_write && !set_default;
	assign base_last = base_cnt_reg >= step_cyc - CNT_W'(1);
	assign timer_expire = ce && timer_run && base_last &&
		step_cnt_reg >= wake_reg[`WTAD_WU_CODE_HI:`WTAD_WU_CODE_LO];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_cnt_reg <= '0;
			step_cnt_reg <= '0;
		end else if (ce) begin
			if (!timer_run || timer_expire) begin
				base_cnt_reg <= '0;
				step_cnt_reg <= '0;
			end else if (base_last) begin
				base_cnt_reg <= '0;
				step_cnt_reg <= step_cnt_reg + 3'd1;
			end else begin
				base_cnt_reg <= base_cnt_reg + CNT_W'(1);
			end
		end
	end

	// timeout interrupt and measurement starts, one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_timeout <= 1'b0;
			amp_meas_start <= 1'b0;
			phase_meas_start <= 1'b0;
			cap_meas_start <= 1'b0;
			irq_phase <= 1'b0;
			irq_cap <= 1'b0;
		end else if (ce) begin
			irq_timeout <= timer_expire && wake_reg[`WTAD_WU_IRQ];
			amp_meas_start <= timer_expire && wake_reg[`WTAD_WU_AMP] &&
				state_reg == WTAD_IDLE;
			phase_meas_start <= timer_expire && wake_reg[`WTAD_WU_PHASE];
			cap_meas_start <= timer_expire && wake_reg[`WTAD_WU_CAP];
			irq_phase <= phase_done && phase_exceeded && wake_reg[`WTAD_WU_PHASE];
			irq_cap <= cap_done && cap_exceeded && wake_reg[`WTAD_WU_CAP];
		end
	end

	// amplitude comparison against the selected reference
	assign ref_sel = ampcfg_reg[`WTAD_AM_SRC] ? avg_reg : ampref_reg;
	assign amp_diff = wtad_absdiff(amp_result, ref_sel);
	assign amp_over = amp_diff > {4'h0, ampcfg_reg[`WTAD_AM_THR_HI:`WTAD_AM_THR_LO]};
	assign amp_take = ce && state_reg == WTAD_MEAS && amp_done && !set_default;

	// amplitude measurement sequence, result and average
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= WTAD_IDLE;
			avg_reg <= `WTAD_BYTE_RESET;
			result_reg <= `WTAD_BYTE_RESET;
			irq_amplitude <= 1'b0;
		end else if (ce) begin
			irq_amplitude <= amp_take && amp_over && wake_reg[`WTAD_WU_AMP];
			if (set_default) begin
				state_reg <= WTAD_IDLE;
				avg_reg <= `WTAD_BYTE_RESET;
				result_reg <= `WTAD_BYTE_RESET;
			end else begin
				unique case (state_reg)
					WTAD_IDLE: begin
						if (timer_expire && wake_reg[`WTAD_WU_AMP]) begin
							state_reg <= WTAD_MEAS;
						end
					end
					WTAD_MEAS: begin
						if (amp_take) begin
							state_reg <= WTAD_IDLE;
							result_reg <= amp_result;
							if (!amp_over || ampcfg_reg[`WTAD_AM_INCL]) begin
								avg_reg <= wtad_avg_update(avg_reg, amp_result,
									ampcfg_reg[`WTAD_AM_WSEL_HI:`WTAD_AM_WSEL_LO]);
							end
						end
					end
				endcase
			end
		end
	end

	// cycles since the timer last restarted, for checking only
	logic [31:0] gap_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_reg <= '0;
		end else if (ce) begin
			gap_reg <= (!timer_run || timer_expire) ? 32'h0000_0000 : gap_reg + 32'h0000_0001;
		end
	end

	sequence s_amp_taken;
		amp_take && wake_reg[`WTAD_WU_AMP];
	endsequence
	sequence s_expire_amp;
		timer_expire && wake_reg[`WTAD_WU_AMP] && state_reg == WTAD_IDLE;
	endsequence

	property p_timeout_span;
		timer_expire |-> gap_reg + 32'h0000_0001 ==
			32'({29'd0, wake_reg[`WTAD_WU_CODE_HI:`WTAD_WU_CODE_LO]} + 32'd1) * 32'(step_cyc);
	endproperty
	a_timeout_span: assert property (p_timeout_span) else $error("timeout span wrong");
	property p_irq_timeout;
		timer_expire |=> irq_timeout == $past(wake_reg[`WTAD_WU_IRQ]);
	endproperty
	a_irq_timeout: assert property (p_irq_timeout) else $error("timeout irq wrong");
	property p_amp_start;
		s_expire_amp |=> amp_meas_start && state_reg == WTAD_MEAS;
	endproperty
	a_amp_start: assert property (p_amp_start) else $error("no amplitude start");
	property p_amp_irq;
		s_amp_taken |=> irq_amplitude == ($past(amp_diff) >
			{4'h0, $past(ampcfg_reg[`WTAD_AM_THR_HI:`WTAD_AM_THR_LO])});
	endproperty
	a_amp_irq: assert property (p_amp_irq) else $error("amplitude irq wrong");
	property p_phase_irq;
		ce && phase_done && phase_exceeded && wake_reg[`WTAD_WU_PHASE] |=> irq_phase;
	endproperty
	a_phase_irq: assert property (p_phase_irq) else $error("phase irq missing");
	property p_cap_irq;
		ce && cap_done && cap_exceeded && wake_reg[`WTAD_WU_CAP] |=> irq_cap;
	endproperty
	a_cap_irq: assert property (p_cap_irq) else $error("capacitance irq missing");
	property p_avg_hold;
		amp_take && amp_over && !ampcfg_reg[`WTAD_AM_INCL] |=> $stable(avg_reg);
	endproperty
	a_avg_hold: assert property (p_avg_hold) else $error("triggering result averaged");
	property p_avg_step;
		amp_take && !amp_over |=> avg_reg == wtad_avg_update($past(avg_reg),
			$past(amp_result), $past(ampcfg_reg[`WTAD_AM_WSEL_HI:`WTAD_AM_WSEL_LO]));
	endproperty
	a_avg_step: assert property (p_avg_step) else $error("average update wrong");
	property p_result;
		amp_take |=> result_reg == $past(amp_result);
	endproperty
	a_result: assert property (p_result) else $error("last result not kept");
	property p_default;
		ce && set_default |=> wake_reg == 8'h00 && ampcfg_reg == 8'h00 && aux_reg == 8'h00
			&& avg_reg == 8'h00;
	endproperty
	a_default: assert property (p_default) else $error("set-default incomplete");
endmodule
`default_nettype wire

// [tb/wtad_top_test.sv]
// self-checking bench of the wake-up timer and amplitude detector
`timescale 1ns/1ps
`default_nettype none
`include "wtad_consts.svh"
`define WT_CHK(nm, ex, got) begin \
	total_checks++; \
	if ((got) !== (ex)) begin \
		bad_count++; \
		$display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module wtad_top_test;
	localparam logic [11:0] A_AUX = 12'h0c0;
	localparam logic [11:0] A_WAKE = 12'h0c4;
	localparam logic [11:0] A_CFG = 12'h0c8;
	localparam logic [11:0] A_REF = 12'h0cc;
	localparam logic [11:0] A_AVG = 12'h0d0;
	localparam logic [11:0] A_RES = 12'h0d4;
	localparam logic [11:0] A_CMD = 12'h0f8;
	localparam logic [1:0] OK = `WTAD_RESP_OKAY;
	localparam logic [1:0] ERR = `WTAD_RESP_SLVERR;
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic wk_en, amp_done, ph_done, ph_exc, cap_done, cap_exc;
	logic [7:0] amp_res, aux_in;
	logic amp_start, ph_start, cap_start, irq_to, irq_amp, irq_ph, irq_cap;
	int bad_count, total_checks;

	// short step counts keep each timeout within a few hundred cycles
	wtad_top #(.FINE_STEP_CYC(10), .COARSE_STEP_CYC(100)) wtad_top_inst (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wakeup_enable(wk_en), .amp_done(amp_done), .amp_result(amp_res),
		.phase_done(ph_done), .phase_exceeded(ph_exc), .cap_done(cap_done),
		.cap_exceeded(cap_exc), .demod_pm_selected(aux_in[7]),
		.external_field_present(aux_in[6]), .transmitter_active(aux_in[5]),
		.crystal_stable(aux_in[4]), .receiver_enabled(aux_in[3]), .receiver_busy(aux_in[2]),
		.peer_detect_active(aux_in[1]), .collision_avoid_detect(aux_in[0]),
		.amp_meas_start(amp_start), .phase_meas_start(ph_start), .cap_meas_start(cap_start),
		.irq_timeout(irq_to), .irq_amplitude(irq_amp), .irq_phase(irq_ph), .irq_cap(irq_cap)
	);

	// 125 mhz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tmo();
		bad_count++;
		$display("[ERR] wait expected answer seen timeout");
		test_done();
	endtask

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] ex);
		logic ap, wp, ar, wr_, bv;
		logic [1:0] rs;
		int n;
		ap = 1'b1;
		wp = 1'b1;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (ap || wp) begin
			@(negedge aclk);
			ar = awready;
			wr_ = wready;
			@(posedge aclk);
			if (ar && ap) begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wr_ && wp) begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
			if (++n > 50) tmo();
		end
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			bv = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (++n > 50) tmo();
		end while (bv !== 1'b1);
		bready <= 1'b0;
		`WT_CHK("bresp", ex, rs)
	endtask

	// one read, data and response sampled on the falling edge before the edge that ends it
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] ex);
		logic ar, rv;
		logic [31:0] d;
		logic [1:0] rs;
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ar = arready;
			@(posedge aclk);
			if (++n > 50) tmo();
		end while (ar !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			rv = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge aclk);
			if (++n > 50) tmo();
		end while (rv !== 1'b1);
		rready <= 1'b0;
		`WT_CHK("rdata", ed, d)
		`WT_CHK("rresp", ex, rs)
	endtask

	// waits for a pulse, n counts the cycles it took
	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			if (n > lim) tmo();
		end while (s !== 1'b1);
		@(posedge aclk);
	endtask

	task automatic saw(ref logic s, input int c, output logic hit);
		hit = 1'b0;
		repeat (c) begin
			@(negedge aclk);
			if (s === 1'b1) hit = 1'b1;
		end
		@(posedge aclk);
	endtask

	task automatic t_regs();
		rd(A_AUX, 0, OK);
		rd(A_WAKE, 0, OK);
		rd(A_CFG, 0, OK);
		rd(A_REF, 0, OK);
		rd(A_AVG, 0, OK);
		rd(A_RES, 0, OK);
		rd(12'h0fc, 0, ERR);
		wr(A_AVG, 32'h0000_00ff, ERR);
		wr(A_REF, 32'h0000_005a, OK);
		rd(A_REF, 32'h0000_005a, OK);
	endtask

	task automatic t_aux();
		logic [7:0] pat[2] = '{8'ha5, 8'h5a};
		foreach (pat[i]) begin
			aux_in <= pat[i];
			repeat (3) @(posedge aclk);
			rd(A_AUX, {24'h00_0000, pat[i]}, OK);
		end
		aux_in <= 8'h00;
	endtask

	// period between two timeout interrupts for range and code pairs
	task automatic t_timer();
		logic [7:0] ctl[3] = '{8'hf8, 8'h18, 8'h88};
		int ex[3] = '{80, 200, 10};
		int n;
		foreach (ctl[i]) begin
			wr(A_WAKE, {24'h00_0000, ctl[i]}, OK);
			wait_hi(irq_to, 1000, n);
			wait_hi(irq_to, 1000, n);
			`WT_CHK("timeout period", ex[i], n)
		end
		wr(A_WAKE, 32'h0000_0000, OK);
	endtask

	// one measurement round on the slowest fine timeout
	task automatic amp_round(input logic [7:0] res, input logic ex_irq);
		int n;
		logic hit;
		wr(A_WAKE, 32'h0000_00f4, OK);
		wait_hi(amp_start, 200, n);
		amp_res <= res;
		amp_done <= 1'b1;
		@(posedge aclk);
		amp_done <= 1'b0;
		saw(irq_amp, 3, hit);
		`WT_CHK("irq_amplitude", ex_irq, hit)
		wr(A_WAKE, 32'h0000_0070, OK);
	endtask

	task automatic t_amp();
		wr(A_CFG, 32'h0000_0040, OK);
		wr(A_REF, 32'h0000_0040, OK);
		amp_round(8'h30, 1'b1);
		rd(A_AVG, 0, OK);
		rd(A_RES, 32'h0000_0030, OK);
		amp_round(8'h44, 1'b0);
		rd(A_AVG, 32'h0000_0011, OK);
		wr(A_CFG, 32'h0000_004b, OK);
		amp_round(8'h41, 1'b1);
		rd(A_AVG, 32'h0000_0017, OK);
	endtask

	task automatic t_phase_cap();
		int n;
		logic hit;
		wr(A_WAKE, 32'h0000_0083, OK);
		wait_hi(ph_start, 200, n);
		ph_done <= 1'b1;
		ph_exc <= 1'b1;
		@(posedge aclk);
		ph_done <= 1'b0;
		ph_exc <= 1'b0;
		saw(irq_ph, 3, hit);
		`WT_CHK("irq_phase", 1'b1, hit)
		wait_hi(cap_start, 200, n);
		cap_done <= 1'b1;
		cap_exc <= 1'b1;
		@(posedge aclk);
		cap_done <= 1'b0;
		cap_exc <= 1'b0;
		saw(irq_cap, 3, hit);
		`WT_CHK("irq_cap", 1'b1, hit)
		wr(A_WAKE, 32'h0000_0000, OK);
	endtask

	task automatic t_setdef();
		wr(A_WAKE, 32'h0000_0070, OK);
		wr(A_REF, 32'h0000_0077, OK);
		wr(A_CMD, 32'h0000_0001, OK);
		rd(A_WAKE, 0, OK);
		rd(A_CFG, 0, OK);
		rd(A_REF, 0, OK);
		rd(A_AVG, 0, OK);
		rd(A_RES, 0, OK);
		rd(A_AUX, 0, OK);
	endtask

	// reset, then the scenarios in turn
	initial begin
		bad_count = 0;
		total_checks = 0;
		aresetn = 1'b0;
		ce = 1'b1;
		wk_en = 1'b1;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		{amp_done, ph_done, ph_exc, cap_done, cap_exc} = '0;
		amp_res = '0;
		aux_in = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_aux();
		t_timer();
		t_amp();
		t_phase_cap();
		t_setdef();
		test_done();
	end
endmodule
`default_nettype wire
